// >>> frame_timing_pkg.sv
// Shared constants and carrier types for the frame timing counters.
// Assumes a single 25 MHz reference clock and same-clock neighbours.
package frame_timing_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses in the controller's memory space)
   localparam logic [7:0] FM_REMAINING_OFS = 8'h38;
   localparam logic [7:0] FM_NUMBER_OFS = 8'h3C;

   // Field positions and widths
   localparam int REMAINING_W = 14;
   localparam int FRAME_COUNT_W = 16;
   localparam int TOGGLE_BIT = 31;
   localparam int SOF_FLAG_BIT = 2;

   // Reset values and the nominal frame interval
   localparam logic [31:0] FM_REMAINING_RST = 32'h0000_0000;
   localparam logic [31:0] FM_NUMBER_RST = 32'h0000_0000;
   localparam logic [13:0] FI_NOMINAL = 14'h2EDF; // 11,999 bit times

   ////////////////////////////////////////////////////////////////////////////
   // Timing: full-speed bit rate against the reference clock rate
   localparam int REF_CLK_KHZ = 25000;
   localparam int FS_BIT_KHZ = 12000;
   localparam int TICK_GCD = 1000;
   localparam logic [5:0] TICK_NUM = 6'(FS_BIT_KHZ / TICK_GCD);
   localparam logic [5:0] TICK_DEN = 6'(REF_CLK_KHZ / TICK_GCD);

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic sel;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic toggle;
      logic [13:0] value;
   } interval_t;

   typedef enum {
      SEQ_IDLE,
      SEQ_WAIT_SOF,
      SEQ_WRITE,
      SEQ_FLAG
   } seq_state_t;

endpackage

// >>> bit_time_tick.sv
// Full-speed bit-time tick generator.
// Assumes ref_clk at the rate named in the package; tick is one cycle wide.
`timescale 1ns/1ns
`default_nettype none
module bit_time_tick (
   input wire logic ref_clk,
   input wire logic reset,
   output logic tick
);
   import frame_timing_pkg::*;

   logic [5:0] acc_q;
   logic [5:0] acc_d;
   logic tick_q;
   logic tick_d;

   ////////////////////////////////////////////////////////////////////////////
   // Fractional accumulator: 12 ticks every 25 clocks, jitter one clock
   always_comb begin
      acc_d = acc_q + TICK_NUM;
      tick_d = 1'b0;
      if (acc_d >= TICK_DEN) begin
         acc_d = acc_d - TICK_DEN; // R15
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule
`default_nettype wire

// >>> sof_sequencer.sv
// Frame boundary sequencer: SOF, frame number write to host memory, flag.
// Assumes the SOF sender and memory writer answer with one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module sof_sequencer (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [15:0] frame_count,
   input wire logic sof_done,
   input wire logic mem_wr_ack,
   output logic sof_req,
   output logic mem_wr_req,
   output logic [15:0] mem_wr_data,
   output logic sof_flag_set,
   output logic list_start,
   output logic busy
);
   import frame_timing_pkg::*;

   seq_state_t state_q, state_d;
   logic sof_req_q, sof_req_d;
   logic wr_req_q, wr_req_d;
   logic [15:0] data_q, data_d;
   logic flag_q, flag_d;
   logic list_q, list_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; the number is captured at start so later writes cannot tear it
   always_comb begin
      state_d = state_q;
      sof_req_d = 1'b0;
      wr_req_d = wr_req_q;
      data_d = data_q;
      flag_d = 1'b0;
      list_d = 1'b0;
      case (state_q)
         SEQ_IDLE: begin
            if (start) begin
               data_d = frame_count;
               sof_req_d = 1'b1;
               state_d = SEQ_WAIT_SOF;
            end
         end
         SEQ_WAIT_SOF: begin
            if (sof_done) begin
               wr_req_d = 1'b1; // R9
               state_d = SEQ_WRITE;
            end
         end
         SEQ_WRITE: begin
            if (mem_wr_ack) begin
               wr_req_d = 1'b0;
               flag_d = 1'b1; // R10
               state_d = SEQ_FLAG;
            end
         end
         SEQ_FLAG: begin
            list_d = 1'b1; // R9
            state_d = SEQ_IDLE;
         end
         default: begin
            state_d = SEQ_IDLE;
            wr_req_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= SEQ_IDLE;
         sof_req_q <= 1'b0;
         wr_req_q <= 1'b0;
         data_q <= 16'h0000;
         flag_q <= 1'b0;
         list_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sof_req_q <= sof_req_d;
         wr_req_q <= wr_req_d;
         data_q <= data_d;
         flag_q <= flag_d;
         list_q <= list_d;
      end
   end

   assign sof_req = sof_req_q;
   assign mem_wr_req = wr_req_q;
   assign mem_wr_data = data_q;
   assign sof_flag_set = flag_q;
   assign list_start = list_q;
   assign busy = (state_q != SEQ_IDLE);
endmodule
`default_nettype wire

// >>> frame_timing_counters.sv
// Frame remaining and frame number counters with their two registers.
// Assumes the interval register, interrupt status and list processing live
// outside and share ref_clk; register accesses arrive on a same-clock port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: The remaining count is a 14-bit down counter in bits 13:0 at offset 38h, bits 30:14 reserved.
// R2: The remaining count drops by one on every full-speed bit time while operational.
// R3: Once the remaining count is zero it reloads the frame interval at the next bit time.
// R4: Each time the count reaches zero the interval toggle is copied into bit 31 of the register.
// R5: Entering the operational state reloads the count from the interval for the next frame.
// R6: The frame number advances each time the remaining count reloads at a frame boundary.
// R7: The frame number rolls over to zero after FFFFh.
// R8: The frame number advances once on entry to the operational state.
// R9: The frame number goes to host memory after the increment and SOF, before list work.
// R10: Once that memory write completes the start-of-frame status flag is set.
// R11: The frame number is read at offset 3Ch as a 16-bit counter.
// R12: Software writes reserved bits of both registers as zero.
// R13: The interval loaded into the counter has a nominal value of 11,999 bit times.
// R14: Software inverts the interval toggle whenever it loads a new interval.
// R15: The decrement tick is derived from the 12 Mbit/s full-speed bit rate.
module frame_timing_counters (
   input wire logic ref_clk,
   input wire logic reset,
   input wire frame_timing_pkg::reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   input wire frame_timing_pkg::interval_t interval,
   input wire logic operational_state,
   input wire logic sof_done,
   input wire logic mem_wr_ack,
   output logic sof_req,
   output logic mem_wr_req,
   output logic [15:0] mem_wr_data,
   output logic start_of_frame_flag_set,
   output logic list_start,
   output logic frame_boundary,
   output logic [13:0] remaining_count,
   output logic [15:0] frame_count
);
   import frame_timing_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic tick;
   logic seq_busy;
   logic [13:0] rem_q, rem_d;
   logic toggle_q, toggle_d;
   logic [15:0] fn_q, fn_d;
   logic op_q, op_d;
   logic start_q, start_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic [13:0] reload_value;
   logic op_entry;
   logic hit_rem;
   logic hit_num;
   logic wr_rem;
   logic wr_num;

   ////////////////////////////////////////////////////////////////////////////
   // Bit-time reference

   // One tick per full-speed bit period, spread over the 25 MHz clock
   bit_time_tick u_tick (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(tick) // R15
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reload source and state entry

   // A zero interval would wedge the counter at zero, so fall back to nominal
   assign reload_value = (interval.value == 14'h0000) ? FI_NOMINAL : interval.value; // R13

   // Entry into the operational state is a rising level from the state logic
   assign op_entry = operational_state & ~op_q;

   // Register decode
   assign hit_rem = (reg_req.addr == FM_REMAINING_OFS);
   assign hit_num = (reg_req.addr == FM_NUMBER_OFS);
   assign wr_rem = reg_req.sel & reg_req.wr & hit_rem;
   assign wr_num = reg_req.sel & reg_req.wr & hit_num;

   ////////////////////////////////////////////////////////////////////////////
   // Counter next state
   // Hardware updates win over a software write landing in the same cycle;
   // the counters must never skip a frame boundary because of a stray write.
   always_comb begin
      rem_d = rem_q;
      toggle_d = toggle_q;
      fn_d = fn_q;
      op_d = operational_state;
      start_d = 1'b0;
      if (op_entry) begin
         rem_d = reload_value; // R5
         fn_d = fn_q + 16'h0001; // R8
         start_d = 1'b1;
      end else if (operational_state && tick) begin
         if (rem_q == 14'h0000) begin
            rem_d = reload_value; // R3
            toggle_d = interval.toggle; // R4
            fn_d = fn_q + 16'h0001; // R6 R7
            start_d = 1'b1;
         end else begin
            rem_d = rem_q - 14'h0001; // R2
         end
      end else begin
         // Reserved bits are dropped, so nonzero writes there do no harm
         if (wr_rem) begin
            rem_d = reg_req.wdata[REMAINING_W-1:0]; // R1 R12
            toggle_d = reg_req.wdata[TOGGLE_BIT];
         end
         if (wr_num) begin
            fn_d = reg_req.wdata[FRAME_COUNT_W-1:0]; // R12
         end
      end
   end

   // Counter registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rem_q <= FM_REMAINING_RST[REMAINING_W-1:0];
         toggle_q <= FM_REMAINING_RST[TOGGLE_BIT];
         fn_q <= FM_NUMBER_RST[FRAME_COUNT_W-1:0];
         op_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         rem_q <= rem_d;
         toggle_q <= toggle_d;
         fn_q <= fn_d;
         op_q <= op_d;
         start_q <= start_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read path

   // Reads show live counter state one cycle after the strobe
   always_comb begin
      rdata_d = 32'h0000_0000;
      ack_d = reg_req.sel;
      if (reg_req.sel && !reg_req.wr) begin
         if (hit_rem) begin
            rdata_d[TOGGLE_BIT] = toggle_q; // R4
            rdata_d[REMAINING_W-1:0] = rem_q; // R1
         end else if (hit_num) begin
            rdata_d[FRAME_COUNT_W-1:0] = fn_q; // R11
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame boundary sequence

   // The sequencer captures the already incremented number on start_q.
   // A boundary arriving while it is still busy is not queued; a frame is
   // about 12,000 bit times, far longer than any sane memory answer.
   sof_sequencer u_seq (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(start_q & ~seq_busy), // R9
      .frame_count(fn_q),
      .sof_done(sof_done),
      .mem_wr_ack(mem_wr_ack),
      .sof_req(sof_req),
      .mem_wr_req(mem_wr_req),
      .mem_wr_data(mem_wr_data),
      .sof_flag_set(start_of_frame_flag_set), // R10
      .list_start(list_start),
      .busy(seq_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops
   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;
   assign frame_boundary = start_q;
   assign remaining_count = rem_q;
   assign frame_count = fn_q;

endmodule
`default_nettype wire

// >>> frame_timing_monitor.sv
// Checker for the frame timing counters, bound to every instance.
// Sees the top module's ports only; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module frame_timing_monitor (
   input wire logic ref_clk,
   input wire logic reset,
   input wire frame_timing_pkg::reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire frame_timing_pkg::interval_t interval,
   input wire logic sof_done,
   input wire logic mem_wr_ack,
   input wire logic sof_req,
   input wire logic mem_wr_req,
   input wire logic [15:0] mem_wr_data,
   input wire logic start_of_frame_flag_set,
   input wire logic list_start,
   input wire logic frame_boundary,
   input wire logic [13:0] remaining_count,
   input wire logic [15:0] frame_count
);
   import frame_timing_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // Register port: answer one cycle on, reads show the live counters
   property p_ack; reg_req.sel |=> reg_ack; endproperty
   a_ack: assert property (p_ack) else $error("access not acknowledged");
   property p_rem_rd; reg_ack && $past(reg_req.addr) == FM_REMAINING_OFS && !$past(reg_req.wr)
      |-> reg_rdata[30:0] == {17'h0, $past(remaining_count)}; endproperty
   a_rem_rd: assert property (p_rem_rd) else $error("bad remaining read");
   property p_num_rd; reg_ack && $past(reg_req.addr) == FM_NUMBER_OFS && !$past(reg_req.wr)
      |-> reg_rdata == {16'h0, $past(frame_count)}; endproperty
   a_num_rd: assert property (p_num_rd) else $error("bad frame number read");
   // Counters; software writes are excluded since they may load anything
   property p_dec; $changed(remaining_count) && $stable(frame_count) && !$past(reg_req.sel)
      |-> remaining_count == $past(remaining_count) - 14'h1; endproperty
   a_dec: assert property (p_dec) else $error("count moved by other than one");
   property p_reload; $past(remaining_count) == 14'h0 && $changed(remaining_count)
      && !$past(reg_req.sel) |-> remaining_count == ($past(interval.value) == 14'h0
      ? FI_NOMINAL : $past(interval.value)); endproperty
   a_reload: assert property (p_reload) else $error("bad reload value");
   property p_fn; $changed(frame_count) && !$past(reg_req.sel)
      |-> frame_count == $past(frame_count) + 16'h1; endproperty
   a_fn: assert property (p_fn) else $error("frame number skipped");
   // Boundary sequence: SOF, then the write, then the flag, then list work
   property p_order; $rose(mem_wr_req) |-> $past(sof_done); endproperty
   a_order: assert property (p_order) else $error("write before SOF");
   property p_hold; mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_data); endproperty
   a_hold: assert property (p_hold) else $error("write request not held");
   property p_data; sof_req |-> mem_wr_data == frame_count; endproperty
   a_data: assert property (p_data) else $error("stale frame number written");
   property p_flag; mem_wr_req && mem_wr_ack
      |=> start_of_frame_flag_set && !mem_wr_req ##1 list_start; endproperty
   a_flag: assert property (p_flag) else $error("flag or list start late");
   property p_cause; start_of_frame_flag_set |-> $past(mem_wr_ack); endproperty
   a_cause: assert property (p_cause) else $error("flag without write");
   c_fb: cover property (frame_boundary);
   c_flag: cover property (start_of_frame_flag_set);
   c_wr: cover property (reg_ack && $past(reg_req.wr));
endmodule
bind frame_timing_counters frame_timing_monitor mon (.*);
`default_nettype wire

// >>> sof_mem_partner.sv
// Stand-in for the SOF sender and the host memory writer.
// Answers each request with a one-cycle pulse, after 1 or 7 cycles.
`timescale 1ns/1ns
`default_nettype none
module sof_mem_partner (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic sof_req,
   input wire logic mem_wr_req,
   output logic sof_done,
   output logic mem_wr_ack
);
   int ws = 0;
   int wm = 0;
   int dly;
   assign dly = slow ? 7 : 1;
   initial begin
      sof_done = 1'b0;
      mem_wr_ack = 1'b0;
   end
   // Write is answered only while requested, never twice per request
   always @(negedge ref_clk) begin
      sof_done <= 1'b0;
      mem_wr_ack <= 1'b0;
      if (reset) ws <= 0;
      else if (ws != 0 && ws >= dly) begin
         sof_done <= 1'b1;
         ws <= 0;
      end else if (ws != 0 || sof_req) ws <= ws + 1;
      if (reset) wm <= 0;
      else if (wm != 0 && wm >= dly) begin
         mem_wr_ack <= 1'b1;
         wm <= 0;
      end else if (!mem_wr_ack && (wm != 0 || mem_wr_req)) wm <= wm + 1;
   end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the frame timing counters.
// Inputs change on the falling edge; the partner answers SOF and writes.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import frame_timing_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   reg_req_t reg_req = '0;
   interval_t interval = '0;
   logic operational_state = 1'b0;
   logic slow = 1'b0;
   logic sof_done, mem_wr_ack, sof_req, mem_wr_req, flag_set, list_start, fb, reg_ack, t;
   logic [31:0] reg_rdata, rd;
   logic [15:0] mem_wr_data, frame_count, fn, r16;
   logic [13:0] remaining_count, v, vp, held;
   int err_count = 0, n_checks = 0, nflag = 0, span = 0, ticks = 0, cyc, seed;
   frame_timing_counters dut (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .interval(interval),
      .operational_state(operational_state), .sof_done(sof_done), .mem_wr_ack(mem_wr_ack),
      .sof_req(sof_req), .mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data),
      .start_of_frame_flag_set(flag_set), .list_start(list_start), .frame_boundary(fb),
      .remaining_count(remaining_count), .frame_count(frame_count));
   sof_mem_partner partner (.ref_clk(ref_clk), .reset(reset), .slow(slow), .sof_req(sof_req),
      .mem_wr_req(mem_wr_req), .sof_done(sof_done), .mem_wr_ack(mem_wr_ack));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Hang guard, flag pulses, and cycles between frame boundaries
   always @(posedge ref_clk) begin
      ticks++;
      if (flag_set === 1'b1) nflag++;
      if (fb === 1'b1) span = 1;
      else span++;
      if (ticks == 40000) begin
         err_count++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One access; the answer is fixed at one cycle, so no wait loop
   task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_req <= '{1'b1, wr, a, d};
      @(negedge ref_clk);
      reg_req <= '0;
      check(32'(reg_ack), 32'h1);
      rd = reg_rdata;
   endtask
   task automatic wait_fb();
      cyc = 0;
      do begin
         @(negedge ref_clk);
         cyc++;
      end while (fb !== 1'b1 && cyc < 30000);
      if (cyc == 30000) check(32'h0, 32'h1);
   endtask
   // Frame of n+1 bit times at 12 of every 25 clocks, within two and a half clocks
   function automatic logic near(input int s, input logic [13:0] n);
      int d;
      d = s * 12 - (int'(n) + 1) * 25;
      return d >= -30 && d <= 30;
   endfunction
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      seed = $urandom(92);
      repeat (16) @(negedge ref_clk);
      reset <= 1'b0;
      // Reset values, an unmapped offset, then writes with reserved bits zero
      reg_acc(1'b0, FM_REMAINING_OFS, '0);
      check(rd, FM_REMAINING_RST);
      reg_acc(1'b0, FM_NUMBER_OFS, '0);
      check(rd, FM_NUMBER_RST);
      reg_acc(1'b0, 8'h40, '0);
      check(rd, 32'h0);
      v = 14'($urandom());
      reg_acc(1'b1, FM_REMAINING_OFS, {1'b1, 17'h0, v});
      reg_acc(1'b0, FM_REMAINING_OFS, '0);
      check(rd, {1'b1, 17'h0, v});
      r16 = 16'($urandom());
      reg_acc(1'b1, FM_NUMBER_OFS, {16'h0, r16});
      reg_acc(1'b0, FM_NUMBER_OFS, '0);
      check(rd, {16'h0, r16});
      reg_acc(1'b1, FM_NUMBER_OFS, 32'h0000_FFFF);
      // Entry reloads and bumps the number once, wrapping past FFFFh
      vp = 14'h1E;
      t = 1'b0;
      interval <= '{t, vp};
      operational_state <= 1'b1;
      wait_fb();
      check(32'(frame_count), 32'h0);
      fn = 16'h0;
      // Frames with fresh intervals; the last asks for the nominal value
      for (int k = 0; k < 6; k++) begin
         v = (k == 5) ? 14'h0 : 14'($urandom_range(60, 25));
         t = ~t;
         interval <= '{t, v};
         slow <= 1'($urandom());
         wait_fb();
         fn++;
         check(32'(frame_count), 32'(fn));
         check(32'(remaining_count), 32'((v == 14'h0) ? FI_NOMINAL : v));
         check(32'(mem_wr_data), 32'(fn - 16'h1));
         check(32'(nflag), 32'(k + 1));
         check(32'(near(span, vp)), 32'h1);
         reg_acc(1'b0, FM_REMAINING_OFS, '0);
         check(32'({rd[31], rd[30:14]}), 32'({t, 17'h0}));
         vp = v;
      end
      // Leaving operation freezes the count
      operational_state <= 1'b0;
      repeat (2) @(negedge ref_clk);
      held = remaining_count;
      repeat (8) @(negedge ref_clk);
      check(32'(remaining_count), 32'(held));
      report_and_stop();
   end
endmodule
`default_nettype wire
